// [rtl/twc_three_wire_config.sv]
// three-wire serial configuration and readback port with ahb-lite access
// Function
// - host sends msb first; each sclk rise shifts into 32-bit register
// - latch_enable rise copies shifted word into one of 16 latches
// - bits 3..0 of shifted word pick the destination latch
// - chip enable low: serial port ignores clock, data and latch
// - readback word leaves on read pin msb first, one bit per edge
// - readback is 18 clocks; 18th releases pin, then latch_enable low
// - frequency readback meaningful only in fsk receive with demod on
// - frequency readback is signed 16-bit two's complement, all bits
// - frequency readback times demod clock over 2^18 gives hertz
// - latch 5 bits 20..23 phase magnitude, bit 24 channel select
// - latch 5 bits 25..29 gain magnitude, 30 channel, 31 polarity
// - calibration tone is an odd multiple of the reference
// - strength word: level 0..6, filter gain 7..8, amp gain 9..10
// - filter calibration readback in low 8 bits, upper bits zero
`timescale 1ns/100ps
module twc_three_wire_config (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sclk,
   input wire logic serial_data_in,
   input wire logic latch_enable,
   output logic serial_read_out,
   output logic serial_read_oe_n,
   output twc_pkg::twc_ir_adj_t ir_adj,
   output twc_pkg::twc_cal_tone_t cal_tone,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import twc_pkg::*;

   typedef enum logic {RB_IDLE, RB_SHIFT} twc_rb_state_t;

   logic [WORD_W-1:0] latch_mem [NUM_LATCH];
   logic [WORD_W-1:0] shift_ff;
   logic sclk_q_ff;
   logic le_q_ff;
   logic [ADDR_W-1:0] last_addr_ff;
   twc_ir_adj_t ir_adj_ff;
   twc_cal_tone_t cal_tone_ff;
   twc_rb_state_t rb_state_ff;
   logic [4:0] rb_cnt_ff;
   logic [RB_W:0] rb_sh_ff;
   logic rd_out_ff;
   logic rd_oe_n_ff;
   logic signed [RB_W-1:0] freq_ff;
   twc_sig_str_t sig_ff;
   logic [6:0] adc_ff;
   logic [7:0] fcal_ff;
   logic [15:0] rev_ff;
   logic [1:0] ctrl_ff;
   logic dph_valid_ff;
   logic dph_write_ff;
   logic [7:0] dph_addr_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;

   logic sclk_rise;
   logic le_rise;
   logic [ADDR_W-1:0] dest_addr;
   logic rb_start;
   logic [RB_W-1:0] rb_word;
   logic aph_take;
   logic [31:0] nxt_hrdata;

   // edges only count while powered
   // both lines are taken as synchronous to ref_clk
   assign sclk_rise = ce & sclk & ~sclk_q_ff;
   assign le_rise = ce & latch_enable & ~le_q_ff;
   assign dest_addr = shift_ff[ADDR_W-1:0];
   // readback starts on latch 7 with enable bit
   assign rb_start = le_rise && dest_addr == LATCH_RB &&
      shift_ff[RB_EN_BIT] && rb_state_ff == RB_IDLE;

   // picks the result word for the selected source
   function automatic logic [RB_W-1:0] rb_source(
      input logic [RB_SEL_W-1:0] sel,
      input logic signed [RB_W-1:0] freq,
      input logic [1:0] ctrl,
      input twc_sig_str_t sig,
      input logic [6:0] adc,
      input logic [7:0] fcal,
      input logic [15:0] rev
   );
      logic [RB_W-1:0] val;
      val = '0;
      case (sel)
         SEL_FREQ: begin
            // zero unless fsk receive with demod on
            if (ctrl[CTRL_FSK_RX] && ctrl[CTRL_DEMOD_ON]) begin
               val = freq;
            end
         end
         SEL_SIG: begin
            val = {5'h00, sig};
         end
         SEL_ADC: begin
            val = {9'h000, adc};
         end
         SEL_REV: begin
            val = rev;
         end
         SEL_FCAL: begin
            val = {8'h00, fcal};
         end
         default: begin
            val = '0;
         end
      endcase
      return val;
   endfunction

   assign rb_word = rb_source(shift_ff[RB_SEL_LSB +: RB_SEL_W], freq_ff,
      ctrl_ff, sig_ff, adc_ff, fcal_ff, rev_ff);

   // edge history
   // history runs with ce low too, so power-up mid-level gives no edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sclk_q_ff <= 1'b0;
         le_q_ff <= 1'b0;
      end else begin
         sclk_q_ff <= sclk;
         le_q_ff <= latch_enable;
      end
   end

   // input shift register
   // no frame counter: extra bits simply push old ones out
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         shift_ff <= WORD_ZERO;
      end else if (!ce) begin
         shift_ff <= WORD_ZERO;
      end else if (sclk_rise) begin
         // msb first shift on sclk rise
         shift_ff <= {shift_ff[WORD_W-2:0], serial_data_in};
      end
   end

   // configuration latches
   // latches survive ce low; only the shift path and readback reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_LATCH; i++) begin
            latch_mem[i] <= WORD_ZERO;
         end
         last_addr_ff <= '0;
      end else if (le_rise) begin
         latch_mem[dest_addr] <= shift_ff;
         last_addr_ff <= dest_addr;
      end
   end

   // decoded fields kept in flops so outputs stay glitch free
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ir_adj_ff <= '0;
         cal_tone_ff <= '0;
      end else if (le_rise && dest_addr == LATCH_IR_ADJ) begin
         ir_adj_ff <= twc_ir_adj_t'(shift_ff[WORD_W-1:IR_ADJ_LSB]);
      end else if (le_rise && dest_addr == LATCH_CAL_TONE) begin
         cal_tone_ff.cal_tone_drive_level <= shift_ff[TONE_LVL_LSB +: 2];
         // low bit forced so the multiple is always odd
         cal_tone_ff.cal_tone_multiple <=
            {shift_ff[TONE_K_LSB +: TONE_K_W], 1'b1};
      end
   end

   // readback sequencer
   // one readout at a time; a start while shifting is ignored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rb_state_ff <= RB_IDLE;
         rb_cnt_ff <= '0;
         rb_sh_ff <= '0;
         rd_out_ff <= 1'b0;
         rd_oe_n_ff <= 1'b1;
      end else if (!ce || (rb_state_ff == RB_SHIFT && !latch_enable)) begin
         // released when unpowered or latch dropped early
         rb_state_ff <= RB_IDLE;
         rb_cnt_ff <= '0;
         rd_out_ff <= 1'b0;
         rd_oe_n_ff <= 1'b1;
      end else begin
         case (rb_state_ff)
            RB_IDLE: begin
               if (rb_start) begin
                  // dummy zero leads so the host can drop it
                  rb_sh_ff <= {1'b0, rb_word};
                  rb_cnt_ff <= '0;
                  rb_state_ff <= RB_SHIFT;
               end
            end
            RB_SHIFT: begin
               if (sclk_rise) begin
                  rb_cnt_ff <= rb_cnt_ff + 5'd1;
                  if (rb_cnt_ff == 5'(RB_CLOCKS - 1)) begin
                     rd_oe_n_ff <= 1'b1;
                     rd_out_ff <= 1'b0;
                     rb_state_ff <= RB_IDLE;
                  end else begin
                     // msb first, one bit per edge
                     // first edge shows the dummy bit
                     rd_out_ff <= rb_sh_ff[RB_W];
                     rd_oe_n_ff <= 1'b0;
                     rb_sh_ff <= {rb_sh_ff[RB_W-1:0], 1'b0};
                  end
               end
            end
            default: begin
               rb_state_ff <= RB_IDLE;
            end
         endcase
      end
   end

   // one decode for both bus paths, so they cannot disagree
   function automatic logic in_map(input logic [31:0] addr);
      return addr[31:8] == 24'h00_0000;
   endfunction

   // ahb-lite address phase capture
   assign aph_take = hsel & hready & htrans[1];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dph_valid_ff <= 1'b0;
         dph_write_ff <= 1'b0;
         dph_addr_ff <= '0;
      end else if (hready) begin
         dph_valid_ff <= aph_take && in_map(haddr);
         dph_write_ff <= hwrite;
         dph_addr_ff <= {haddr[7:2], 2'b00};
      end
   end

   // software-written result sources and control
   // these stand in for the radio's own measurements
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         freq_ff <= '0;
         sig_ff <= '0;
         adc_ff <= '0;
         fcal_ff <= '0;
         rev_ff <= REV_RESET;
         ctrl_ff <= '0;
      end else if (dph_valid_ff && dph_write_ff) begin
         case (dph_addr_ff)
            // value kept raw; hertz scaling is the reader's job
            OFS_FREQ: freq_ff <= hwdata[RB_W-1:0];
            OFS_SIG: sig_ff <= twc_sig_str_t'(hwdata[10:0]);
            OFS_ADC: adc_ff <= hwdata[6:0];
            OFS_FCAL: fcal_ff <= hwdata[7:0];
            OFS_REV: rev_ff <= hwdata[15:0];
            OFS_CTRL: ctrl_ff <= hwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // read data picked in address phase, registered into data phase
   // latch mirror is read-only; writes there are dropped silently
   always_comb begin
      nxt_hrdata = WORD_ZERO;
      if (!in_map(haddr)) begin
         nxt_hrdata = WORD_ZERO;
      end else if (haddr[7:0] <= OFS_LATCH_LAST) begin
         nxt_hrdata = latch_mem[haddr[5:2]];
      end else begin
         case ({haddr[7:2], 2'b00})
            OFS_FREQ: nxt_hrdata = {16'h0000, freq_ff};
            OFS_SIG: nxt_hrdata = {21'h00_0000, sig_ff};
            OFS_ADC: nxt_hrdata = {25'h000_0000, adc_ff};
            OFS_FCAL: nxt_hrdata = {24'h00_0000, fcal_ff};
            OFS_REV: nxt_hrdata = {16'h0000, rev_ff};
            OFS_CTRL: nxt_hrdata = {30'h0000_0000, ctrl_ff};
            OFS_STAT: nxt_hrdata = {23'h00_0000, ce, last_addr_ff,
               3'h0, rb_state_ff == RB_SHIFT};
            default: nxt_hrdata = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hrdata_ff <= WORD_ZERO;
         hreadyout_ff <= 1'b0;
      end else begin
         // zero wait states; a write landing in the next read's address
         // phase is not forwarded, the master idles there anyway
         hreadyout_ff <= 1'b1;
         if (aph_take && !hwrite) begin
            hrdata_ff <= nxt_hrdata;
         end
      end
   end

   // always okay; no error response exists in this map
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
      end
   end

   assign serial_read_out = rd_out_ff;
   assign serial_read_oe_n = rd_oe_n_ff;
   assign ir_adj = ir_adj_ff;
   assign cal_tone = cal_tone_ff;
   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
endmodule

// [rtl/twc_pkg.sv]
// shared constants and types for the three-wire configuration port
package twc_pkg;
   // serial word layout
   localparam int WORD_W = 32;
   localparam int NUM_LATCH = 16;
   localparam int ADDR_W = 4;
   localparam int RB_W = 16;
   localparam int RB_CLOCKS = 18;
   localparam logic [ADDR_W-1:0] LATCH_IR_ADJ = 4'h5;
   localparam logic [ADDR_W-1:0] LATCH_CAL_TONE = 4'h6;
   localparam logic [ADDR_W-1:0] LATCH_RB = 4'h7;
   localparam int RB_EN_BIT = 8;
   localparam int RB_SEL_LSB = 4;
   localparam int RB_SEL_W = 3;
   localparam int IR_ADJ_LSB = 20;
   localparam int TONE_K_LSB = 24;
   localparam int TONE_K_W = 4;
   localparam int TONE_LVL_LSB = 28;
   // readback source codes
   localparam logic [2:0] SEL_FREQ = 3'h0;
   localparam logic [2:0] SEL_SIG = 3'h1;
   localparam logic [2:0] SEL_ADC = 3'h2;
   localparam logic [2:0] SEL_REV = 3'h3;
   localparam logic [2:0] SEL_FCAL = 3'h4;
   // bus register byte offsets
   localparam logic [7:0] OFS_LATCH_LAST = 8'h3c;
   localparam logic [7:0] OFS_FREQ = 8'h40;
   localparam logic [7:0] OFS_SIG = 8'h44;
   localparam logic [7:0] OFS_ADC = 8'h48;
   localparam logic [7:0] OFS_FCAL = 8'h4c;
   localparam logic [7:0] OFS_REV = 8'h50;
   localparam logic [7:0] OFS_CTRL = 8'h54;
   localparam logic [7:0] OFS_STAT = 8'h58;
   // control bits
   localparam int CTRL_FSK_RX = 0;
   localparam int CTRL_DEMOD_ON = 1;
   // arbitrary neutral revision word, not a real part code
   localparam logic [15:0] REV_RESET = 16'h0a5a;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   typedef struct packed {
      logic gain_corr_polarity;
      logic gain_corr_channel_sel;
      logic [4:0] gain_corr_magnitude;
      logic phase_corr_channel_sel;
      logic [3:0] phase_corr_magnitude;
   } twc_ir_adj_t;
   typedef struct packed {
      logic [1:0] cal_tone_drive_level;
      logic [4:0] cal_tone_multiple;
   } twc_cal_tone_t;
   typedef struct packed {
      logic [1:0] amp_gain;
      logic [1:0] filter_gain;
      logic [6:0] signal_strength_level;
   } twc_sig_str_t;
endpackage

// [bench/twc_monitor.sv]
// assertion checker on the three-wire port pins
`timescale 1ns/100ps
module twc_monitor (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sclk,
   input wire logic latch_enable,
   input wire logic serial_read_out,
   input wire logic serial_read_oe_n,
   input wire twc_pkg::twc_ir_adj_t ir_adj,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   import twc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence rd_unmapped;
      hsel && hready && htrans[1] && !hwrite && (haddr[31:8] != 24'h0);
   endsequence
   AST_RST_VALUES: assert property ($rose(rst_n) |->
      serial_read_oe_n && !hreadyout && ir_adj == 12'h0)
      else $error("reset values wrong");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("error response");
   AST_ZERO_WAIT: assert property ($past(rst_n) |-> hreadyout)
      else $error("wait state inserted");
   AST_CE_OFF: assert property (!ce |=> serial_read_oe_n)
      else $error("pin driven with ce low");
   AST_LE_OFF: assert property (!latch_enable |=> serial_read_oe_n)
      else $error("pin driven with latch low");
   AST_DRIVE_CAUSE: assert property ($fell(serial_read_oe_n) |->
      ce && latch_enable && $past(sclk))
      else $error("pin driven without clock");
   AST_OUT_RELEASED: assert property (serial_read_oe_n |->
      !serial_read_out)
      else $error("released pin not zero");
   AST_OUT_STANDS: assert property (!serial_read_oe_n &&
      $changed(serial_read_out) |-> $past(sclk))
      else $error("read bit changed off clock");
   AST_UNMAPPED: assert property (rd_unmapped |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_IR_CAUSE: assert property ($changed(ir_adj) |->
      $past(latch_enable))
      else $error("correction changed without latch");
endmodule

// [bench/twc_host.sv]
// host model driving the serial lines
`timescale 1ns/100ps
module twc_host (
   input wire logic ref_clk,
   input wire logic serial_read_out,
   input wire logic serial_read_oe_n,
   output logic sclk,
   output logic serial_data_in,
   output logic latch_enable
);
   import twc_pkg::*;
   logic pin_seen;
   // a released line shows the opposite level, so a late read shows up
   assign pin_seen = serial_read_oe_n ? ~serial_read_out : serial_read_out;
   initial begin
      sclk = 1'b0;
      serial_data_in = 1'b0;
      latch_enable = 1'b0;
   end
   // each level two cycles, port samples it on ref_clk
   task automatic pulse(input logic b, output logic r);
      sclk <= 1'b0;
      serial_data_in <= b;
      repeat (2) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (2) @(posedge ref_clk);
      r = pin_seen;
   endtask
   task automatic send(input logic [31:0] w);
      logic r;
      for (int i = 31; i >= 0; i--) pulse(w[i], r);
   endtask
   task automatic write_latch(input logic [31:0] w);
      send(w);
      latch_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      latch_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic read_back(input logic [2:0] sel, output logic [15:0] v,
                            output logic rel);
      logic r;
      send({23'h0, 1'b1, 1'b0, sel, LATCH_RB});
      latch_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      pulse(1'b0, r);
      for (int i = 15; i >= 0; i--) pulse(1'b0, v[i]);
      pulse(1'b0, r);
      rel = serial_read_oe_n;
      latch_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // strobe dropped mid-readout, pin must let go
   task automatic cut_read(input logic [2:0] sel, output logic rel);
      logic r;
      send({23'h0, 1'b1, 1'b0, sel, LATCH_RB});
      latch_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      repeat (3) pulse(1'b0, r);
      latch_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rel = serial_read_oe_n;
   endtask
endmodule

// [bench/twc_testbench.sv]
// self-checking bench for the three-wire port
`timescale 1ns/100ps
module testbench;
   import twc_pkg::*;
   typedef struct {
      logic [2:0] sel;
      logic [7:0] ofs;
      logic [15:0] val;
      logic [15:0] exp;
      logic [15:0] mask;
   } twc_row_t;
   // strength upper bits are don't-care, hence the mask
   twc_row_t rows [6] = '{
      '{SEL_SIG, OFS_SIG, 16'hffff, 16'h07ff, 16'h07ff},
      '{SEL_ADC, OFS_ADC, 16'h00d5, 16'h0055, 16'h007f},
      '{SEL_REV, OFS_REV, 16'h1234, 16'h1234, 16'hffff},
      '{SEL_FCAL, OFS_FCAL, 16'hffa5, 16'h00a5, 16'hffff},
      '{SEL_FREQ, OFS_FREQ, 16'h8001, 16'h8001, 16'hffff},
      '{3'h5, OFS_REV, 16'h1234, 16'h0000, 16'hffff}};
   logic [3:0] rx_seq [5] = '{4'h1, 4'h3, 4'h0, 4'h5, 4'h4};
   logic [11:0] sweep [3] = '{12'h123, 12'h456, 12'h789};
   logic [6:0] lvl [3] = '{7'h30, 7'h12, 7'h25};
   logic [11:0] keep;
   logic [6:0] best;
   logic ref_clk = 1'b0;
   logic rst_n, ce, sclk, serial_data_in, latch_enable;
   logic serial_read_out, serial_read_oe_n, hsel, hwrite, hready;
   logic hreadyout, hresp, rel;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] v;
   twc_ir_adj_t ir_adj;
   twc_cal_tone_t cal_tone;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   always #5 ref_clk = ~ref_clk;
   assign hready = hreadyout;
   twc_three_wire_config dut (.ref_clk, .rst_n, .ce, .sclk,
      .serial_data_in, .latch_enable, .serial_read_out, .serial_read_oe_n,
      .ir_adj, .cal_tone, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp);
   twc_host host (.ref_clk, .serial_read_out, .serial_read_oe_n, .sclk,
      .serial_data_in, .latch_enable);
   task automatic check(input string name, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      r = hrdata;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // a hang costs a mismatch
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      @(posedge ref_clk);
      check("oe_n", 32'(serial_read_oe_n), 32'h1);
      ahb(1'b0, {24'h0, OFS_REV}, 32'h0, rd);
      check("rev", rd, 32'(REV_RESET));
      for (int i = 0; i < 5; i++) host.write_latch({28'h0, rx_seq[i]});
      host.write_latch(32'ha5b0_0005);
      host.write_latch(32'h3700_0006);
      check("ir_adj", 32'(ir_adj), 32'h0000_0a5b);
      check("tone", 32'(cal_tone), 32'h0000_006f);
      // mirror is read-only
      ahb(1'b1, 32'h14, 32'h0, rd);
      ahb(1'b0, 32'h14, 32'h0, rd);
      check("latch5", rd, 32'ha5b0_0005);
      host.write_latch(32'h0800_0000);
      ahb(1'b0, 32'h0, 32'h0, rd);
      check("latch0", rd, 32'h0800_0000);
      ce <= 1'b0;
      host.write_latch(32'h0000_0005);
      check("ir_adj_ce", 32'(ir_adj), 32'h0000_0a5b);
      ce <= 1'b1;
      ahb(1'b1, {24'h0, OFS_CTRL}, 32'h3, rd);
      foreach (rows[i]) begin
         ahb(1'b1, {24'h0, rows[i].ofs}, {16'h0, rows[i].val}, rd);
         host.read_back(rows[i].sel, v, rel);
         check("rb", 32'(v & rows[i].mask), 32'(rows[i].exp));
         check("rel", 32'(rel), 32'h1);
      end
      // frequency result withheld in fsk receive with demod off
      ahb(1'b1, {24'h0, OFS_CTRL}, 32'h1, rd);
      host.read_back(SEL_FREQ, v, rel);
      check("freq", 32'(v), 32'h0);
      ahb(1'b0, 32'h0000_0100, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      check("resp", 32'(hresp), 32'h0);
      // sweep corrections, keep the lowest strength
      best = 7'h7f;
      keep = 12'h000;
      for (int i = 0; i < 3; i++) begin
         host.write_latch({sweep[i], 20'h0_0005});
         ahb(1'b1, {24'h0, OFS_SIG}, {25'h0, lvl[i]}, rd);
         host.read_back(SEL_SIG, v, rel);
         check("sweep_rb", 32'(v & 16'h07ff), {25'h0, lvl[i]});
         if (v[6:0] < best) begin
            best = v[6:0];
            keep = sweep[i];
         end
      end
      host.write_latch({keep, 20'h0_0005});
      check("ir_keep", 32'(ir_adj), 32'h0000_0456);
      host.cut_read(SEL_REV, rel);
      check("cut_rel", 32'(rel), 32'h1);
      ahb(1'b0, {24'h0, OFS_STAT}, 32'h0, rd);
      check("stat", rd, 32'h0000_0170);
      final_report();
   end
endmodule
bind twc_three_wire_config twc_monitor mon (.ref_clk, .rst_n, .ce, .sclk,
   .latch_enable, .serial_read_out, .serial_read_oe_n, .ir_adj, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp);
